// ---- hdl/srctl_top.sv ----
// Sonar ranging sequencer: burst, blanking, gain steps and return flag
`timescale 1ns/1ps
// Operation
// R01 - A rising cycle trigger starts a new measurement cycle.
// R02 - Controller waits 5 ms after power-up before the first trigger; the bench host waits only 64 cycles.
// R03 - Every trigger rise sends exactly 16 drive pulses.
// R04 - Oscillator runs only while triggered; first 16 cycles at resonator/8.5.
// R05 - After transmit the oscillator runs at resonator/4.5 until cycle end.
// R06 - Drive output stops after the burst; oscillator keeps running near 93.3 kHz.
// R07 - Receive input ignored for 3.8 ms after the trigger rise.
// R08 - Blanking inhibit high ends blanking early and enables receive.
// R09 - Forced blank disables receive and clears the return flag anytime.
// R10 - Four-bit gain code steps 0 to 11, last step coded 1011.
// R11 - Steps end at their tabled times; step 11 holds until trigger falls.
// R12 - Unblanked active receive sets return flag until force or next cycle.
// R13 - Trigger low ends the cycle, stops oscillator, returns to idle.
module srctl_top #(
    parameter int                   BLANK_CYC = srctl_pkg::BLANK_CYC,
    parameter srctl_pkg::srctl_steps_t STEP_CYC = srctl_pkg::STEP_END_CYC
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic cycle_trigger_in_i,
    input  wire logic receive_detect_in_i,
    input  wire logic blank_inhibit_in_i,
    input  wire logic force_blank_in_i,
    output logic      osc_out_o,
    output logic      transducer_drive_out_o,
    output logic      return_detect_out_o,
    output logic      gain_bit0_o,
    output logic      gain_bit1_o,
    output logic      gain_bit2_o,
    output logic      gain_bit3_o
);
    import srctl_pkg::*;

    logic [3:0]         meta_q;
    logic [3:0]         sync_q;
    logic               trig_s;
    logic               rec_s;
    logic               inhibit_s;
    logic               force_s;
    logic               trig_q;
    logic               start;
    logic               tick;
    logic               tx_q;
    logic [PULSE_W-1:0] pulse_cnt_q;
    logic               osc_q;
    logic               drive_q;
    logic [TIMER_W-1:0] timer_q;
    logic               blank_q;
    logic               echo_q;
    logic [GAIN_W-1:0]  step_q;

    // Every pin crosses two flops; first stage feeds only the second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= {force_blank_in_i, blank_inhibit_in_i, receive_detect_in_i,
                       cycle_trigger_in_i};
            sync_q <= meta_q;
        end
    end

    assign trig_s    = sync_q[0];
    assign rec_s     = sync_q[1];
    assign inhibit_s = sync_q[2];
    assign force_s   = sync_q[3];

    // Trigger edge detection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_s;
        end
    end

    assign start = trig_s && !trig_q; // R01

    srctl_osc_div u_div (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (trig_s && !start),
        .slow_i    (tx_q),
        .tick_o    (tick)
    );

    // Oscillator and burst: tx phase counts completed oscillator periods
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_q        <= 1'b0;
            pulse_cnt_q <= '0;
            osc_q       <= 1'b0;
            drive_q     <= 1'b0;
        end else if (!trig_s) begin
            tx_q        <= 1'b0; // R13
            osc_q       <= 1'b0; // R04
            drive_q     <= 1'b0;
        end else if (start) begin
            tx_q        <= 1'b1; // R03
            pulse_cnt_q <= '0;
            osc_q       <= 1'b0;
            drive_q     <= 1'b0;
        end else if (tick) begin
            osc_q   <= !osc_q;
            drive_q <= tx_q && !osc_q; // R06
            // Falling half completes one period of the burst
            if (tx_q && osc_q) begin
                pulse_cnt_q <= pulse_cnt_q + 1'b1;
                if (pulse_cnt_q == PULSE_W'(TX_PULSES - 1)) begin
                    tx_q <= 1'b0; // R05
                end
            end
        end
    end

    // Cycle timer saturates so late cycles never wrap into early steps
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_q <= '0;
        end else if (!trig_s || start) begin
            timer_q <= '0;
        end else if (timer_q != '1) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    // Internal blanking; inhibit may only shorten it, never extend
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blank_q <= 1'b1;
        end else if (!trig_s || start) begin
            blank_q <= 1'b1;
        end else if (inhibit_s) begin
            blank_q <= 1'b0; // R08
        end else if (timer_q >= TIMER_W'(BLANK_CYC - 1)) begin
            blank_q <= 1'b0; // R07
        end
    end

    // Return flag; forced blank dominates any receive in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            echo_q <= 1'b0;
        end else if (force_s || start) begin
            echo_q <= 1'b0; // R09
        end else if (trig_s && !blank_q && rec_s) begin
            echo_q <= 1'b1; // R12
        end
    end

    // Gain step advance at each tabled end time
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_q <= '0;
        end else if (!trig_s || start) begin
            step_q <= '0;
        end else if (step_q != GAIN_LAST &&
                     timer_q == TIMER_W'(STEP_CYC[step_q] - 1)) begin
            step_q <= step_q + 1'b1; // R11
        end
    end

    // Gain lines change together from one register
    assign gain_bit0_o            = step_q[0]; // R10
    assign gain_bit1_o            = step_q[1];
    assign gain_bit2_o            = step_q[2];
    assign gain_bit3_o            = step_q[3];
    assign osc_out_o              = osc_q;
    assign transducer_drive_out_o = drive_q;
    assign return_detect_out_o    = echo_q;

    property p_start;
        @(posedge clk_i) disable iff (!reset_n_i)
        start |=> tx_q && pulse_cnt_q == '0 && timer_q == '0 && step_q == '0;
    endproperty
    a_start: assert property (p_start) else $error("cycle did not restart"); // R01

    property p_burst_len;
        @(posedge clk_i) disable iff (!reset_n_i)
        ($fell(tx_q) && trig_s && !start) |-> pulse_cnt_q == PULSE_W'(TX_PULSES);
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst length wrong"); // R03

    property p_osc_off;
        @(posedge clk_i) disable iff (!reset_n_i)
        !trig_s |=> !osc_q && !drive_q && !tx_q;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator ran while idle"); // R04

    property p_drive_quiet;
        @(posedge clk_i) disable iff (!reset_n_i)
        !tx_q |=> !drive_q;
    endproperty
    a_drive_quiet: assert property (p_drive_quiet) else $error("drive after burst"); // R06

    property p_blank_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (trig_s && blank_q && !echo_q) |=> !echo_q;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("return during blanking"); // R07

    property p_inhibit;
        @(posedge clk_i) disable iff (!reset_n_i)
        (trig_s && !start && inhibit_s) |=> !blank_q;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit ignored"); // R08

    property p_force;
        @(posedge clk_i) disable iff (!reset_n_i)
        force_s |=> !echo_q;
    endproperty
    a_force: assert property (p_force) else $error("forced blank ignored"); // R09

    property p_echo;
        @(posedge clk_i) disable iff (!reset_n_i)
        (trig_s && !start && !blank_q && rec_s && !force_s) |=> echo_q [*1];
    endproperty
    a_echo: assert property (p_echo) else $error("return not flagged"); // R12

    property p_step_inc;
        @(posedge clk_i) disable iff (!reset_n_i)
        (trig_s && $past(trig_s) && $changed(step_q)) |-> step_q == $past(step_q) + 1'b1;
    endproperty
    a_step_inc: assert property (p_step_inc) else $error("gain step skipped"); // R10

    property p_step_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (step_q == GAIN_LAST && trig_s) |=> (step_q == GAIN_LAST || !trig_s || start);
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("last step left early"); // R11
endmodule

// ---- hdl/srctl_pkg.sv ----
// Constants for the sonar ranging sequencer
package srctl_pkg;
    localparam int CLK_HZ       = 100_000_000;
    localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
    localparam int RESONATOR_HZ = 420_000;
    // Divide ratios held doubled so 8.5 and 4.5 stay integral
    localparam int DIV_TX_X2    = 17;
    localparam int DIV_RX_X2    = 9;
    // Half periods of the oscillator output, rounded down
    localparam int HALF_TX_CYC  = (CLK_HZ / RESONATOR_HZ) * DIV_TX_X2 / 4;
    localparam int HALF_RX_CYC  = (CLK_HZ / RESONATOR_HZ) * DIV_RX_X2 / 4;
    localparam int TX_PULSES    = 16;
    localparam int PULSE_W      = 5;
    localparam int BLANK_US     = 3800;
    localparam int BLANK_CYC    = BLANK_US * CYC_PER_US;
    localparam int GAIN_STEPS   = 12;
    localparam int GAIN_W       = 4;
    localparam int TIMER_W      = 23;
    localparam logic [GAIN_W-1:0] GAIN_LAST = 4'hB;

    typedef int srctl_steps_t [GAIN_STEPS-1];

    // End of each timed gain step, microseconds from the trigger rise
    localparam srctl_steps_t STEP_END_US = '{2380, 5120, 7870, 10610, 13350, 16090,
                                             18840, 21580, 27070, 32550, 38040};

    function automatic srctl_steps_t srctl_us_to_cyc(srctl_steps_t us);
        srctl_steps_t cyc;
        for (int i = 0; i < GAIN_STEPS - 1; i++) begin
            cyc[i] = us[i] * CYC_PER_US;
        end
        return cyc;
    endfunction

    localparam srctl_steps_t STEP_END_CYC = srctl_us_to_cyc(STEP_END_US);
endpackage

// ---- hdl/srctl_osc_div.sv ----
// Oscillator divider producing half-period tick enables
`timescale 1ns/1ps
module srctl_osc_div #(
    parameter int HALF_TX = srctl_pkg::HALF_TX_CYC,
    parameter int HALF_RX = srctl_pkg::HALF_RX_CYC,
    parameter int CNT_W   = 12
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic run_i,
    input  wire logic slow_i,
    output logic      tick_o
);
    import srctl_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] last;

    // Terminal count follows the divide ratio in force
    assign last   = slow_i ? CNT_W'(HALF_TX - 1) : CNT_W'(HALF_RX - 1);
    assign tick_o = run_i && (cnt_q >= last);

    // Restart from zero whenever the cycle is idle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else if (!run_i || tick_o) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    property p_rx_span;
        @(posedge clk_i) disable iff (!reset_n_i)
        (run_i && !slow_i && $past(run_i) && !$past(slow_i)) |-> cnt_q < CNT_W'(HALF_RX);
    endproperty
    a_rx_span: assert property (p_rx_span) else $error("fast divider overran"); // R05
endmodule

// ---- verification/srctl_partner_model.sv ----
// Host trigger logic and echo source facing the sonar sequencer
`timescale 1ns/1ps
module srctl_partner_model #(
    parameter int POWERUP_CYC = 64
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        run_i,
    input  wire logic [15:0] echo_dly_i,
    output logic             trigger_o,
    output logic             receive_o
);
    logic [15:0] wait_q;
    logic [15:0] age_q;

    // Settling count after power-up, shortened so the run stays brief
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) wait_q <= 16'h0000;
        else if (wait_q < POWERUP_CYC) wait_q <= wait_q + 16'h0001;
    end

    // Trigger follows the request only once settled
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) trigger_o <= 1'b0;
        else trigger_o <= run_i && (wait_q >= POWERUP_CYC);
    end

    // One 8-cycle echo per cycle; detector low elsewhere
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            age_q     <= 16'h0000;
            receive_o <= 1'b0;
        end else begin
            age_q     <= trigger_o ? age_q + 16'h0001 : 16'h0000;
            receive_o <= trigger_o && age_q >= echo_dly_i && age_q < echo_dly_i + 16'h0008;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the sonar ranging sequencer
`timescale 1ns/1ps
module tb_top;
    import srctl_pkg::*;
    localparam int           BLANK = 200;
    localparam srctl_steps_t STEPS = '{300, 600, 900, 1200, 1500, 1800,
                                       2100, 2400, 2700, 3000, 3300};
    logic        clk_i    = 1'b0;
    logic        reset_n  = 1'b0;
    logic        run_q    = 1'b0;
    logic [15:0] echo_dly = 16'h0000;
    logic        inhibit  = 1'b0;
    logic        force_b  = 1'b0;
    logic        trig, recv, osc, drv, ret, g0, g1, g2, g3;
    logic        drv_prev = 1'b0;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          run_len = 0;
    int          drv_rises = 0;
    int          osc_runs[$];
    int          d, r0, d0;
    wire logic [3:0] gain = {g3, g2, g1, g0};

    srctl_partner_model srctl_partner_model_inst (.clk_i(clk_i), .reset_n_i(reset_n),
        .run_i(run_q), .echo_dly_i(echo_dly), .trigger_o(trig), .receive_o(recv));
    srctl_top #(.BLANK_CYC(BLANK), .STEP_CYC(STEPS)) srctl_top_inst (.clk_i(clk_i),
        .reset_n_i(reset_n), .cycle_trigger_in_i(trig), .receive_detect_in_i(recv),
        .blank_inhibit_in_i(inhibit), .force_blank_in_i(force_b), .osc_out_o(osc),
        .transducer_drive_out_o(drv), .return_detect_out_o(ret), .gain_bit0_o(g0),
        .gain_bit1_o(g1), .gain_bit2_o(g2), .gain_bit3_o(g3));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Expected half period for a doubled divide ratio
    function automatic int half_exp(input int div_x2);
        return (CLK_HZ / RESONATOR_HZ) * div_x2 / 4;
    endfunction
    // Gain code is the step number in binary
    function automatic logic [3:0] gain_exp(input int k);
        return k[3:0];
    endfunction
    // Echo counts only once blanking is over
    function automatic logic flag_exp(input int dly);
        return dly > BLANK;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start(input int dly);
        @(posedge clk_i);
        run_q    <= 1'b1;
        echo_dly <= dly[15:0];
    endtask
    // Drop the trigger, then leave enough low time for the fall to be seen
    task automatic stop();
        @(posedge clk_i);
        run_q <= 1'b0;
        cyc(6);
        check({osc, drv, gain}, 6'h00);
        cyc(3);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Burst edge count and oscillator high-run lengths, measured in cycles
    always @(posedge clk_i) begin
        if (drv && !drv_prev) drv_rises++;
        drv_prev = drv;
        if (osc) run_len++;
        else if (run_len != 0) begin
            osc_runs.push_back(run_len);
            run_len = 0;
        end
    end

    // Cuts a hang short well past the expected run length
    initial begin
        cyc(95000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h017B));
        cyc(16);
        reset_n <= 1'b1;
        cyc(2);
        check({osc, drv, ret, gain}, 7'h00);
        cyc(80);
        // Long cycle: full burst, every gain step, echo then forced clear
        d  = $urandom_range(600, 240);
        r0 = osc_runs.size();
        d0 = drv_rises;
        start(d);
        cyc(150);
        for (int k = 0; k < GAIN_STEPS; k++) begin
            check(gain, gain_exp(k));
            cyc(300);
        end
        check(ret, 1'b1);
        force_b <= 1'b1;
        cyc(6);
        check(ret, 1'b0);
        force_b <= 1'b0;
        cyc(50000);
        check(gain, 4'hB);
        check(ret, 1'b0);
        stop();
        check(drv_rises - d0, TX_PULSES);
        check(osc_runs[r0], half_exp(DIV_TX_X2));
        check(osc_runs[r0 + 17], half_exp(DIV_RX_X2));
        // Inhibit lets an early echo through; flag outlives the cycle
        inhibit <= 1'b1;
        start(60);
        cyc(900);
        check(ret, 1'b1);
        inhibit <= 1'b0;
        stop();
        check(ret, 1'b1);
        // Early echo blanked, and the new cycle clears the old flag
        start(100);
        cyc(900);
        check(ret, 1'b0);
        stop();
        // Random echo times on either side of the blanking end
        repeat (4) begin
            d = $urandom_range(1, 0) ? $urandom_range(150, 20) : $urandom_range(600, 240);
            start(d);
            cyc(900);
            check(ret, flag_exp(d));
            stop();
        end
        // Reset early in the burst, before the first drive pulse: outputs read idle in reset and stay idle after release
        start(400);
        cyc(300);
        reset_n <= 1'b0;
        cyc(2);
        check({osc, drv, ret, gain}, 7'h00);
        reset_n <= 1'b1;
        cyc(2);
        check({osc, drv, ret, gain}, 7'h00);
        stop();
        finish_test();
    end
endmodule
